// ### verilog/rfs_pkg.sv
// Shared constants, types and register map of the regeneration supervisor.
package rfs_pkg;

  // ==========================================================================
  // Clock and timing
  localparam longint CLK_HZ        = 200_000_000;
  localparam longint FLT_CLR_S     = 10;
  localparam longint LAMP_TEST_S   = 3;
  localparam longint FAN_HOLD_MIN  = 10;
  localparam longint FLASH_HALF_MS = 250;
  localparam longint FLASH_GAP_MS  = 1000;

  localparam logic [39:0] FLT_CLR_CYC   = 40'(FLT_CLR_S * CLK_HZ);
  localparam logic [39:0] LAMP_TEST_CYC = 40'(LAMP_TEST_S * CLK_HZ);
  localparam logic [39:0] FAN_HOLD_CYC  = 40'(FAN_HOLD_MIN * 60 * CLK_HZ);
  localparam logic [39:0] FLASH_CYC     = 40'(FLASH_HALF_MS * CLK_HZ / 1000);
  localparam logic [39:0] GAP_CYC       = 40'(FLASH_GAP_MS * CLK_HZ / 1000);

  // ==========================================================================
  // Register map
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam logic [31:0] CTRL_RST      = 32'h00000000;
  localparam int          CTRL_EN_MODE  = 0;
  localparam int          CTRL_DSAT_CLR = 1;
  localparam int          CTRL_PROC_CLR = 2;
  localparam int          STAT_FLT_LSB  = 0;
  localparam int          STAT_READY    = 4;
  localparam int          STAT_REGEN    = 5;
  localparam int          STAT_FAN      = 6;
  localparam int          STAT_RUN      = 7;
  localparam int          STAT_LAST_LSB = 8;
  localparam int          STAT_PROC_LSB = 12;

  // ==========================================================================
  // Fault positions and codes
  localparam int         FLT_PHASE  = 0;
  localparam int         FLT_TEMP   = 1;
  localparam int         FLT_OVOLT  = 2;
  localparam int         FLT_DSAT   = 3;
  localparam logic [2:0] CODE_NONE  = 3'h0;
  localparam logic [2:0] CODE_ONE   = 3'h1;
  localparam logic [2:0] CODE_THREE = 3'h3;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_LAMP  = 2'h0,
    ST_PHASE = 2'h1,
    ST_RUN   = 2'h3
  } rfs_state_e;

  typedef struct packed {
    logic       acPresent;
    logic       thirdPhaseOk;
    logic       busAbovePeak;
    logic       busOverVolt;
    logic       overTemp;
    logic       switchDesat;
    logic       overCurrent;
    logic       recallIn;
    logic       threePhase;
    logic [3:0] procErr;
  } rfs_pins_s;

  typedef struct packed {
    logic greenLamp;
    logic redLamp;
    logic yellowLamp;
    logic fanOn;
    logic readyClosed;
    logic regenGate;
  } rfs_outs_s;

  localparam int PIN_W = $bits(rfs_pins_s);

endpackage : rfs_pkg

// ### verilog/rfs_controller.sv
// Supervisor, fault latch, lamp coder and APB registers of the regen unit.
`timescale 1ns/10ps

// Contract
// - Fault flashes: phase1, temp2, volt3, desat4.
// - Any fault stops regeneration and shows code.
// - Faults auto clear except desat, manual.
// - Phase loss on feedback loss, clears 10s.
// - Overvoltage in operation, clears 10s after.
// - Overtemp fault follows over-limit indication.
// - Ready contact open on fault, closed ready.
// - Processor error: red steady, yellow flashes.
// - Recall while idle flashes last fault.
// - Enable variant: three toggles recall fault.
// - Fault records written to nonvolatile store.
// - Power-up: red, yellow, fan on 3s.
// - Lamps toggle once or thrice per phases.
// - Then lamps off, ready closes, start done.
// - Yellow lamp only while moving current; the code also lights it in lamp test, phase toggles and processor error.
// - Regen runs while bus above line peak.
// - Fan on during regen, 10 min hold.
// - Hot unit keeps fan running regardless.
// - Overcurrent folds back regeneration output.
// - Works on 50 or 60Hz, no setting.
// - Green lamp while AC supply present.
module rfs_controller #(
  parameter logic [39:0] FLT_CLR_CYCLES  = rfs_pkg::FLT_CLR_CYC,
  parameter logic [39:0] LAMP_CYCLES     = rfs_pkg::LAMP_TEST_CYC,
  parameter logic [39:0] FAN_HOLD_CYCLES = rfs_pkg::FAN_HOLD_CYC,
  parameter logic [39:0] FLASH_CYCLES    = rfs_pkg::FLASH_CYC,
  parameter logic [39:0] GAP_CYCLES      = rfs_pkg::GAP_CYC
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Field pins and sensors
  input  wire rfs_pkg::rfs_pins_s pinsIn,
  // Lamps, fan, contact and gate
  output rfs_pkg::rfs_outs_s     outs,
  // Nonvolatile fault record
  input  wire logic [2:0]        nvRdData,
  output logic                   nvWrEn,
  output logic      [2:0]        nvWrData
);

  // ==========================================================================
  // Code selection helper
  function automatic logic [2:0] rfs_next_code(input logic [3:0] flt,
                                               input logic [2:0] cur);
    logic [2:0] above;
    logic [2:0] lowest;
    above  = rfs_pkg::CODE_NONE;
    lowest = rfs_pkg::CODE_NONE;
    for (int i = 3; i >= 0; i--)
    begin
      if (flt[i])
      begin
        lowest = 3'(i + 1);
        if (3'(i + 1) > cur)
        begin
          above = 3'(i + 1);
        end
      end
    end
    return (above != rfs_pkg::CODE_NONE) ? above : lowest;
  endfunction : rfs_next_code

  // ==========================================================================
  // Pin synchronisers
  logic [rfs_pkg::PIN_W-1:0] pinRaw;
  logic [rfs_pkg::PIN_W-1:0] syncA_ff;
  logic [rfs_pkg::PIN_W-1:0] syncB_ff;
  rfs_pkg::rfs_pins_s        pinS;

  assign pinRaw = pinsIn;
  assign pinS   = rfs_pkg::rfs_pins_s'(syncB_ff);

  // The chain runs through reset so that it holds true pin levels when
  // reset lifts; a cleared chain would read as a lost phase at start-up.
  for (genvar g = 0; g < rfs_pkg::PIN_W; g++)
  begin : g_sync
    always_ff @(posedge sys_clk)
    begin
      syncA_ff[g] <= pinRaw[g];
      syncB_ff[g] <= syncA_ff[g];
    end
  end

  // ==========================================================================
  // APB register access
  logic        ctrlHit;
  logic        statHit;
  logic        wrAcc;
  logic        desatClr;
  logic        procClr;
  logic        enMode_ff;
  logic [31:0] statWord;
  logic [31:0] prdata_ff;

  assign ctrlHit  = paddr == rfs_pkg::CTRL_OFS;
  assign statHit  = paddr == rfs_pkg::STAT_OFS;
  assign wrAcc    = psel && penable && pwrite && ctrlHit;
  assign desatClr = wrAcc && pwdata[rfs_pkg::CTRL_DSAT_CLR];
  assign procClr  = wrAcc && pwdata[rfs_pkg::CTRL_PROC_CLR];
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !(ctrlHit || (statHit && !pwrite));
  assign prdata   = prdata_ff;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      enMode_ff <= rfs_pkg::CTRL_RST[rfs_pkg::CTRL_EN_MODE];
      prdata_ff <= 32'h00000000;
    end
    else
    begin
      if (wrAcc)
      begin
        enMode_ff <= pwdata[rfs_pkg::CTRL_EN_MODE];
      end
      if (psel && !penable && !pwrite)
      begin
        prdata_ff <= ctrlHit ? {31'h00000000, enMode_ff} :
                     statHit ? statWord : 32'h00000000;
      end
    end
  end

  // ==========================================================================
  // Start-up sequence
  rfs_pkg::rfs_state_e state_ff;
  rfs_pkg::rfs_state_e nxtState;
  logic [39:0]         stTmr_ff;
  logic                gapStart;
  logic                gapEnd;
  logic [2:0]          code_ff;

  always_comb
  begin
    nxtState = state_ff;
    case (state_ff)
      rfs_pkg::ST_LAMP:
        if (stTmr_ff == LAMP_CYCLES - 40'h1)
        begin
          nxtState = rfs_pkg::ST_PHASE;
        end
      rfs_pkg::ST_PHASE:
        if (gapStart && code_ff != rfs_pkg::CODE_NONE)
        begin
          nxtState = rfs_pkg::ST_RUN;
        end
      rfs_pkg::ST_RUN:
        nxtState = rfs_pkg::ST_RUN;
      default:
        nxtState = rfs_pkg::ST_LAMP;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_ff <= rfs_pkg::ST_LAMP;
      stTmr_ff <= 40'h0;
    end
    else
    begin
      state_ff <= nxtState;
      stTmr_ff <= (state_ff == rfs_pkg::ST_LAMP) ? stTmr_ff + 40'h1 : 40'h0;
    end
  end

  // ==========================================================================
  // Fault detection and latching
  logic        running;
  logic [1:0]  tCond;
  logic [1:0]  tFlt_ff;
  logic [39:0] tCnt_ff [2];
  logic        tempFlt_ff;
  logic        desat_ff;
  logic [3:0]  procLat_ff;
  logic [3:0]  fltVec;
  logic        fltAny;
  logic        procAny;

  assign running = state_ff == rfs_pkg::ST_RUN;
  assign tCond   = {pinS.busOverVolt && running, !pinS.thirdPhaseOk};
  assign fltVec  = {desat_ff, tFlt_ff[1], tempFlt_ff, tFlt_ff[0]};
  assign fltAny  = |fltVec;
  assign procAny = |procLat_ff;

  for (genvar k = 0; k < 2; k++)
  begin : g_timed
    always_ff @(posedge sys_clk)
    begin
      if (!rst_b)
      begin
        tFlt_ff[k] <= 1'b0;
        tCnt_ff[k] <= 40'h0;
      end
      else if (tCond[k])
      begin
        tFlt_ff[k] <= 1'b1;
        tCnt_ff[k] <= FLT_CLR_CYCLES;
      end
      else if (tFlt_ff[k] && tCnt_ff[k] > 40'h1)
      begin
        tCnt_ff[k] <= tCnt_ff[k] - 40'h1;
      end
      else
      begin
        tFlt_ff[k] <= 1'b0;
        tCnt_ff[k] <= 40'h0;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      tempFlt_ff <= 1'b0;
      desat_ff   <= 1'b0;
      procLat_ff <= 4'h0;
    end
    else
    begin
      tempFlt_ff <= pinS.overTemp;
      desat_ff   <= pinS.switchDesat || (desat_ff && !desatClr);
      procLat_ff <= pinS.procErr | (procLat_ff & ~{4{procClr}});
    end
  end

  // ==========================================================================
  // Regeneration gate and fan
  logic        regenReq;
  logic        regenGate;
  logic        runEnable;
  logic [39:0] fanCnt_ff;

  assign runEnable = !enMode_ff || pinS.recallIn;
  assign regenReq  = running && pinS.busAbovePeak && !fltAny && !procAny &&
                     runEnable;
  assign regenGate = regenReq && !pinS.overCurrent;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      fanCnt_ff <= 40'h0;
    end
    else if (regenReq)
    begin
      fanCnt_ff <= FAN_HOLD_CYCLES;
    end
    else if (fanCnt_ff != 40'h0)
    begin
      fanCnt_ff <= fanCnt_ff - 40'h1;
    end
  end

  // ==========================================================================
  // Fault recall and nonvolatile record
  logic       idle;
  logic       recallPrev_ff;
  logic       recallRise;
  logic [1:0] togCnt_ff;
  logic       recallPend_ff;
  logic       recallHit;
  logic       recallDone;
  logic       loaded_ff;
  logic [3:0] fltPrev_ff;
  logic [3:0] newFlt;
  logic [2:0] lastFault_ff;
  logic       nvWr_ff;

  assign idle       = running && !regenReq && !fltAny && !procAny;
  assign recallRise = pinS.recallIn && !recallPrev_ff;
  assign recallHit  = idle && recallRise &&
                      (!enMode_ff || togCnt_ff == 2'h2);
  assign recallDone = gapStart && running && !fltAny && !procAny &&
                      (code_ff != rfs_pkg::CODE_NONE ||
                       lastFault_ff == rfs_pkg::CODE_NONE);
  assign newFlt     = fltVec & ~fltPrev_ff;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      recallPrev_ff <= 1'b0;
      togCnt_ff     <= 2'h0;
      recallPend_ff <= 1'b0;
      loaded_ff     <= 1'b0;
      fltPrev_ff    <= 4'h0;
      lastFault_ff  <= rfs_pkg::CODE_NONE;
      nvWr_ff       <= 1'b0;
    end
    else
    begin
      recallPrev_ff <= pinS.recallIn;
      if (recallHit || regenReq)
      begin
        togCnt_ff <= 2'h0;
      end
      else if (idle && recallRise)
      begin
        togCnt_ff <= togCnt_ff + 2'h1;
      end
      recallPend_ff <= recallHit || (recallPend_ff && !recallDone);
      loaded_ff     <= 1'b1;
      fltPrev_ff    <= fltVec;
      nvWr_ff       <= newFlt != 4'h0;
      if (newFlt != 4'h0)
      begin
        lastFault_ff <= rfs_next_code(newFlt, rfs_pkg::CODE_NONE);
      end
      else if (!loaded_ff)
      begin
        lastFault_ff <= nvRdData;
      end
    end
  end

  assign nvWrEn   = nvWr_ff;
  assign nvWrData = lastFault_ff;

  // ==========================================================================
  // Flash code engine
  logic [39:0] tmr_ff;
  logic [3:0]  idx_ff;
  logic        gap_ff;
  logic        flashOn_ff;
  logic [3:0]  lastIdx;
  logic        moreHalf;
  logic        tmrZero;
  logic [2:0]  nxtCode;
  logic [2:0]  phaseCode;

  assign lastIdx   = {code_ff, 1'b0} - 4'h1;
  assign moreHalf  = code_ff != rfs_pkg::CODE_NONE && idx_ff < lastIdx;
  assign tmrZero   = tmr_ff == 40'h0;
  assign gapStart  = tmrZero && !gap_ff && !moreHalf;
  assign gapEnd    = tmrZero && gap_ff;
  assign phaseCode = pinS.threePhase ? rfs_pkg::CODE_THREE :
                     rfs_pkg::CODE_ONE;
  assign nxtCode   = !running ? phaseCode :
                     procAny ? rfs_next_code(procLat_ff,
                                             rfs_pkg::CODE_NONE) :
                     fltAny ? rfs_next_code(fltVec, code_ff) :
                     recallPend_ff ? lastFault_ff : rfs_pkg::CODE_NONE;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || state_ff == rfs_pkg::ST_LAMP)
    begin
      tmr_ff     <= 40'h0;
      idx_ff     <= 4'h0;
      gap_ff     <= 1'b1;
      code_ff    <= rfs_pkg::CODE_NONE;
      flashOn_ff <= 1'b0;
    end
    else if (!tmrZero)
    begin
      tmr_ff <= tmr_ff - 40'h1;
    end
    else if (gapEnd)
    begin
      gap_ff     <= 1'b0;
      code_ff    <= nxtCode;
      idx_ff     <= 4'h0;
      flashOn_ff <= nxtCode != rfs_pkg::CODE_NONE;
      tmr_ff     <= FLASH_CYCLES - 40'h1;
    end
    else if (moreHalf)
    begin
      idx_ff     <= idx_ff + 4'h1;
      flashOn_ff <= !flashOn_ff;
      tmr_ff     <= FLASH_CYCLES - 40'h1;
    end
    else
    begin
      gap_ff     <= 1'b1;
      flashOn_ff <= 1'b0;
      tmr_ff     <= GAP_CYCLES - 40'h1;
    end
  end

  // ==========================================================================
  // Output registers
  rfs_pkg::rfs_outs_s outs_ff;
  rfs_pkg::rfs_outs_s nxtOuts;

  always_comb
  begin
    nxtOuts           = '0;
    nxtOuts.greenLamp = pinS.acPresent;
    nxtOuts.regenGate = regenGate;
    case (state_ff)
      rfs_pkg::ST_LAMP:
      begin
        nxtOuts.redLamp    = 1'b1;
        nxtOuts.yellowLamp = 1'b1;
        nxtOuts.fanOn      = 1'b1;
      end
      rfs_pkg::ST_PHASE:
      begin
        nxtOuts.redLamp    = !flashOn_ff;
        nxtOuts.yellowLamp = !flashOn_ff;
        nxtOuts.fanOn      = pinS.overTemp;
      end
      rfs_pkg::ST_RUN:
      begin
        nxtOuts.redLamp     = procAny || flashOn_ff;
        nxtOuts.yellowLamp  = procAny ? flashOn_ff : regenGate;
        nxtOuts.fanOn       = regenReq || fanCnt_ff != 40'h0 ||
                              pinS.overTemp;
        nxtOuts.readyClosed = !fltAny && !procAny;
      end
      default:
        nxtOuts.redLamp = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      outs_ff <= '0;
    end
    else
    begin
      outs_ff <= nxtOuts;
    end
  end

  assign outs = outs_ff;

  always_comb
  begin
    statWord = 32'h00000000;
    statWord[rfs_pkg::STAT_FLT_LSB +: 4]  = fltVec;
    statWord[rfs_pkg::STAT_READY]         = outs_ff.readyClosed;
    statWord[rfs_pkg::STAT_REGEN]         = outs_ff.regenGate;
    statWord[rfs_pkg::STAT_FAN]           = outs_ff.fanOn;
    statWord[rfs_pkg::STAT_RUN]           = running;
    statWord[rfs_pkg::STAT_LAST_LSB +: 3] = lastFault_ff;
    statWord[rfs_pkg::STAT_PROC_LSB +: 4] = procLat_ff;
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  property p_ready_open;
    fltAny |=> !outs_ff.readyClosed;
  endproperty
  a_ready_open: assert property (p_ready_open)
    else $error("Ready contact closed while a fault is present.");

  property p_desat_hold;
    desat_ff && !desatClr |=> desat_ff;
  endproperty
  a_desat_hold: assert property (p_desat_hold)
    else $error("Desaturation fault cleared without a manual clear.");

  property p_fault_stop;
    (fltAny || procAny) |-> !regenGate;
  endproperty
  a_fault_stop: assert property (p_fault_stop)
    else $error("Regeneration gated on while faulted.");

  property p_fold;
    pinS.overCurrent |-> !regenGate;
  endproperty
  a_fold: assert property (p_fold)
    else $error("Gate on during overcurrent.");

  property p_phase_set;
    !pinS.thirdPhaseOk |=> tFlt_ff[0] && fltVec[rfs_pkg::FLT_PHASE];
  endproperty
  a_phase_set: assert property (p_phase_set)
    else $error("Phase loss not raised.");

  property p_temp_clr;
    $fell(pinS.overTemp) |=> !fltVec[rfs_pkg::FLT_TEMP];
  endproperty
  a_temp_clr: assert property (p_temp_clr)
    else $error("Overtemperature fault did not clear.");

  property p_lamp_test;
    state_ff == rfs_pkg::ST_LAMP |=>
      outs_ff.redLamp && outs_ff.yellowLamp && outs_ff.fanOn;
  endproperty
  a_lamp_test: assert property (p_lamp_test)
    else $error("Lamp test outputs wrong.");

  property p_proc_red;
    running && procAny |=> outs_ff.redLamp && !outs_ff.readyClosed;
  endproperty
  a_proc_red: assert property (p_proc_red)
    else $error("Processor error without steady red.");

  property p_fan_regen;
    regenReq |=> outs_ff.fanOn [*2];
  endproperty
  a_fan_regen: assert property (p_fan_regen)
    else $error("Fan not running during regeneration.");

  property p_hot_fan;
    running && pinS.overTemp |=> outs_ff.fanOn;
  endproperty
  a_hot_fan: assert property (p_hot_fan)
    else $error("Fan off while hot.");

  property p_yellow;
    running && !procAny && !regenGate |=> !outs_ff.yellowLamp;
  endproperty
  a_yellow: assert property (p_yellow)
    else $error("Yellow lamp lit without regeneration.");

  property p_nv_write;
    newFlt != 4'h0 |=> nvWrEn ##1 !nvWrEn || fltVec != fltPrev_ff;
  endproperty
  a_nv_write: assert property (p_nv_write)
    else $error("Fault record not written.");

  c_regen: cover property (regenGate);
  c_desat: cover property ($rose(desat_ff));
  c_recall: cover property ($rose(recallPend_ff));
  c_proc: cover property (running && procAny && outs_ff.yellowLamp);

endmodule : rfs_controller

// ### verification/rfs_plant_model.sv
// Outside controller model: recall line and persistent fault record.
`timescale 1ns/10ps
module rfs_plant_model (
  // Clock
  input  wire logic       sys_clk,
  // Commands from the bench
  input  wire logic       cmdGo,
  input  wire logic [1:0] cmdCount,
  input  wire logic       base,
  // Recall or enable line
  output logic            recallIn,
  // Persistent record
  input  wire logic       nvWrEn,
  input  wire logic [2:0] nvWrData,
  output logic      [2:0] nvRdData
);
  // ==========================================================================
  // Behaviour
  initial
  begin
    recallIn = 1'b0;
    nvRdData = 3'h0;
  end

  // The record survives whatever the controller does.
  always @(posedge sys_clk)
    if (nvWrEn) nvRdData <= nvWrData;

  // Each toggle leaves the base level and returns to it.
  always @(posedge sys_clk)
    if (cmdGo)
      for (int i = 0; i < int'(cmdCount); i++)
      begin
        recallIn <= !base;
        repeat (4) @(posedge sys_clk);
        recallIn <= base;
        repeat (4) @(posedge sys_clk);
      end
    else
      recallIn <= base;
endmodule : rfs_plant_model

// ### verification/test_rfs_controller.sv
// Self-checking bench of the regeneration supervisor.
`timescale 1ns/10ps
module test_rfs_controller;
  // ==========================================================================
  // Signals
  logic               sys_clk, rst_b, psel, penable, pwrite;
  logic               pready, pslverr, recallIn, nvWrEn, err;
  logic               cmdGo, base;
  logic [1:0]         cmdCount;
  logic [2:0]         nvWrData, nvRdData;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  rfs_pkg::rfs_pins_s pins, pinsIn;
  rfs_pkg::rfs_outs_s outs;
  int                 n, n_fail, num_checks;
  int                 cycles = 0;

  assign pinsIn = {pins[12:6], recallIn, pins[4:0]};

  rfs_controller #(
    .FLT_CLR_CYCLES(40'hC8), .LAMP_CYCLES(40'h32),
    .FAN_HOLD_CYCLES(40'h12C), .FLASH_CYCLES(40'h5), .GAP_CYCLES(40'h14)
  ) rfs_controller_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinsIn(pinsIn), .outs(outs),
    .nvRdData(nvRdData), .nvWrEn(nvWrEn), .nvWrData(nvWrData));

  rfs_plant_model rfs_plant_model_i (
    .sys_clk(sys_clk), .cmdGo(cmdGo), .cmdCount(cmdCount), .base(base),
    .recallIn(recallIn), .nvWrEn(nvWrEn), .nvWrData(nvWrData),
    .nvRdData(nvRdData));

  // ==========================================================================
  // Clock and timeout
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      n_fail++;
      results();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wt(input int c);
    repeat (c) @(posedge sys_clk);
  endtask : wt

  // Counts the pulses of one code, from one long dark gap to the next.
  task automatic flashes(input logic red, output int cnt,
                         input logic once = 1'b0);
    int   q, k;
    logic l, p;
    cnt = 0;
    k = 0;
    p = 1'b0;
    for (int s = int'(once); s < 2; s++)
    begin
      q = 0;
      while ((q < 15 || (s == 1 && cnt == 0)) && k < 400)
      begin
        @(posedge sys_clk);
        k++;
        l = red ? outs.redLamp : outs.yellowLamp;
        if (s == 1 && l && !p) cnt++;
        q = l ? 0 : q + 1;
        p = l;
      end
    end
    if (k >= 400) n_fail++;
  endtask : flashes

  // ==========================================================================
  // Scenarios
  task automatic startup(input int ph);
    int   r;
    logic p;
    r = 0;
    p = 1'b1;
    wt(5);
    chk("lampTest", 32'h3C, 32'(outs));
    repeat (105)
    begin
      @(posedge sys_clk);
      if (outs.redLamp && !p) r++;
      p = outs.redLamp;
    end
    chk("phaseToggles", 32'(ph), 32'(r));
    chk("startDone", 32'h22, 32'(outs));
  endtask : startup

  task automatic regs();
    apb(1'b0, rfs_pkg::CTRL_OFS, 32'h0);
    chk("ctrlReset", rfs_pkg::CTRL_RST, rd);
    apb(1'b1, rfs_pkg::CTRL_OFS, 32'h1);
    apb(1'b0, rfs_pkg::CTRL_OFS, 32'h0);
    chk("ctrlMode", 32'h1, rd);
    apb(1'b1, rfs_pkg::CTRL_OFS, 32'h0);
    apb(1'b1, rfs_pkg::STAT_OFS, 32'h0);
    chk("statWrErr", 32'h1, 32'(err));
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, 32'(err));
    apb(1'b0, rfs_pkg::STAT_OFS, 32'h0);
    chk("statReady", 32'h1, 32'(rd[rfs_pkg::STAT_READY]));
  endtask : regs

  task automatic regen();
    pins.busAbovePeak <= 1'b1;
    wt(6);
    chk("regenOn", 32'h2F, 32'(outs));
    pins.overCurrent <= 1'b1;
    wt(6);
    chk("foldBack", 32'h0, 32'(outs.regenGate));
    pins.overCurrent <= 1'b0;
    pins.busAbovePeak <= 1'b0;
    wt(250);
    chk("fanHold", 32'h26, 32'(outs));
    pins.overTemp <= 1'b1;
    wt(6);
    chk("hotReady", 32'h0, 32'(outs.readyClosed));
    flashes(1'b1, n);
    chk("tempCode", 32'h2, 32'(n));
    wt(50);
    chk("hotFan", 32'h1, 32'(outs.fanOn));
    pins.overTemp <= 1'b0;
    wt(6);
    chk("coolRdy", 32'h3, 32'({outs.readyClosed, !outs.fanOn}));
  endtask : regen

  task automatic desat();
    pins.busAbovePeak <= 1'b1;
    pins.switchDesat <= 1'b1;
    wt(4);
    pins.switchDesat <= 1'b0;
    wt(6);
    chk("desatStop", 32'h0, 32'({outs.regenGate, outs.readyClosed}));
    chk("record4", 32'h4, 32'(nvRdData));
    flashes(1'b1, n);
    chk("desatCode", 32'h4, 32'(n));
    apb(1'b1, rfs_pkg::CTRL_OFS, 32'h2);
    wt(6);
    chk("desatClr", 32'h3, 32'({outs.regenGate, outs.readyClosed}));
    pins.busAbovePeak <= 1'b0;
    wt(6);
  endtask : desat

  task automatic timed(input int b, input int code);
    pins <= pins ^ (13'h1 << b);
    wt(6);
    flashes(1'b1, n);
    chk("timedCode", 32'(code), 32'(n));
    pins <= pins ^ (13'h1 << b);
    wt(190);
    chk("timedHeld", 32'h0, 32'(outs.readyClosed));
    wt(20);
    chk("timedClr", 32'h1, 32'(outs.readyClosed));
  endtask : timed

  task automatic proc();
    for (int i = 0; i < 4; i++)
    begin
      pins.procErr <= 4'h1 << i;
      wt(4);
      pins.procErr <= 4'h0;
      wt(6);
      flashes(1'b0, n);
      chk("procCode", 32'(i + 1), 32'(n));
      chk("procRed", 32'h1, 32'(outs.redLamp));
      apb(1'b1, rfs_pkg::CTRL_OFS, 32'h4);
      wt(6);
      chk("procClr", 32'h1, 32'({outs.redLamp, outs.readyClosed}));
    end
  endtask : proc

  task automatic recall(input logic en);
    apb(1'b1, rfs_pkg::CTRL_OFS, {31'h0, en});
    base <= en;
    wt(10);
    cmdCount <= en ? 2'h3 : 2'h1;
    cmdGo <= 1'b1;
    @(posedge sys_clk);
    cmdGo <= 1'b0;
    flashes(1'b1, n, 1'b1);
    chk("recallCode", 32'h3, 32'(n));
    base <= 1'b0;
    apb(1'b1, rfs_pkg::CTRL_OFS, 32'h0);
  endtask : recall

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    {psel, penable, pwrite, cmdGo, base} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    cmdCount = 2'h0;
    n_fail = 0;
    num_checks = 0;
    // Supply present, third phase seen, three phases.
    pins = 13'h1810;
    wt(6);
    rst_b <= 1'b1;
    startup(3);
    regs();
    regen();
    desat();
    timed(11, 1);
    timed(9, 3);
    chk("record3", 32'h3, 32'(nvRdData));
    proc();
    recall(1'b0);
    recall(1'b1);
    rst_b <= 1'b0;
    pins.threePhase <= 1'b0;
    wt(6);
    rst_b <= 1'b1;
    startup(1);
    results();
  end
endmodule : test_rfs_controller
